// *** hw/qfs_phase_gen.sv ***
`timescale 1ns/100ps
module qfs_phase_gen
   import qfs_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic nrst_i,
   // phase outputs, one-hot
   output logic      phase_one_clock_o,
   output logic      phase_two_clock_o,
   output logic      phase_three_clock_o,
   output logic      phase_four_clock_o
);
   import qfs_pkg::*;

   qfs_phase_e             ph_q;
   qfs_phase_e             ph_d;
   logic [PHASE_COUNT-1:0] hot_q;
   logic [PHASE_COUNT-1:0] hot_d;

   always_comb
   begin
      // fixed order one, two, three, four, then repeat
      case (ph_q)
         QFS_PH1: ph_d = QFS_PH2;
         QFS_PH2: ph_d = QFS_PH3;
         QFS_PH3: ph_d = QFS_PH4;
         QFS_PH4: ph_d = QFS_PH1;
         default: ph_d = QFS_PH1;
      endcase
      if (!nrst_i)
      begin
         ph_d = QFS_PH1;
      end
      // one-hot copy of the next state is registered, so no decode glitch
      // ever reaches a phase pin
      hot_d       = {PHASE_COUNT{1'b0}};
      hot_d[ph_d] = 1'b1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      ph_q  <= ph_d;
      hot_q <= hot_d;
   end

   assign phase_one_clock_o   = hot_q[0];
   assign phase_two_clock_o   = hot_q[1];
   assign phase_three_clock_o = hot_q[2];
   assign phase_four_clock_o  = hot_q[3];

endmodule : qfs_phase_gen

// *** hw/qfs_pkg.sv ***
package qfs_pkg;

   // phases per instruction cycle
   localparam int unsigned PHASE_COUNT = 4;
   localparam int unsigned PHASE_W     = 2;

   // phase indices
   localparam logic [1:0] PH_ONE   = 2'h0;
   localparam logic [1:0] PH_TWO   = 2'h1;
   localparam logic [1:0] PH_THREE = 2'h2;
   localparam logic [1:0] PH_FOUR  = 2'h3;

   // default widths
   localparam int unsigned PC_W     = 11;
   localparam int unsigned INSTR_W  = 14;
   localparam int unsigned DADDR_W  = 7;
   localparam int unsigned DATA_W   = 8;

   // reset values
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;

   typedef enum logic [1:0] {
      QFS_PH1,
      QFS_PH2,
      QFS_PH3,
      QFS_PH4
   } qfs_phase_e;

endpackage : qfs_pkg

// *** hw/qfs_sequencer.sv ***
`timescale 1ns/100ps
// How it works
// - input clock divided by four into four non-overlapping phases in fixed order
// - an instruction cycle is exactly four phases, one through four
// - program counter increments in phase one, starting each fetch cycle
// - program word is read in phases three and four of fetch, captured as phase four ends
// - fetch overlaps execute, giving one instruction per cycle sustained
// - jumps take two cycles, the word read from the target minus one in phase four is loaded and discarded
// - fetched word enters instruction register in phase one, executes phases two to four
// - data operand read in phase two, result written in phase four
module qfs_sequencer
   import qfs_pkg::*;
#(
   parameter int unsigned PC_WIDTH    = PC_W,
   parameter int unsigned INSTR_WIDTH = INSTR_W,
   parameter int unsigned DADDR_WIDTH = DADDR_W,
   parameter int unsigned DATA_WIDTH  = DATA_W
)
(
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   // program memory
   output logic [PC_WIDTH-1:0]         prog_addr_o,
   output logic                        prog_rd_o,
   input  wire logic [INSTR_WIDTH-1:0] prog_data_i,
   // instruction register and decoder
   output logic [INSTR_WIDTH-1:0]      instr_reg_o,
   output logic                        instr_valid_o,
   input  wire logic                   jump_i,
   input  wire logic [PC_WIDTH-1:0]    jump_target_i,
   input  wire logic                   mem_rd_req_i,
   input  wire logic                   mem_wr_req_i,
   input  wire logic [DADDR_WIDTH-1:0] mem_addr_i,
   input  wire logic [DATA_WIDTH-1:0]  result_i,
   output logic [DATA_WIDTH-1:0]       operand_o,
   // data memory
   output logic [DADDR_WIDTH-1:0]      dmem_addr_o,
   output logic                        dmem_rd_o,
   output logic                        dmem_wr_o,
   output logic [DATA_WIDTH-1:0]       dmem_wdata_o,
   input  wire logic [DATA_WIDTH-1:0]  dmem_rdata_i,
   // phase outputs
   output logic                        phase_one_clock_o,
   output logic                        phase_two_clock_o,
   output logic                        phase_three_clock_o,
   output logic                        phase_four_clock_o
);
   import qfs_pkg::*;

   initial
   begin
      if (PC_WIDTH < 1 || PC_WIDTH > 16 || INSTR_WIDTH < 1 || DATA_WIDTH < 1
          || DADDR_WIDTH < 1 || PC_WIDTH > PC_W)
      begin
         $error("qfs_sequencer: unsupported width parameters");
      end
   end

   logic ph1;
   logic ph2;
   logic ph3;
   logic ph4;

   // phases as flip-flop outputs; internal copies lead them by nothing
   qfs_phase_gen u_phase (
      .sys_clk_i           (sys_clk_i),
      .nrst_i              (nrst_i),
      .phase_one_clock_o   (ph1),
      .phase_two_clock_o   (ph2),
      .phase_three_clock_o (ph3),
      .phase_four_clock_o  (ph4)
   );

   // phase outputs come from the phase generator's one-hot register
   assign phase_one_clock_o   = ph1;
   assign phase_two_clock_o   = ph2;
   assign phase_three_clock_o = ph3;
   assign phase_four_clock_o  = ph4;

   // fetch side state
   logic [PC_WIDTH-1:0]    pc_q;
   logic [PC_WIDTH-1:0]    pc_d;
   logic [INSTR_WIDTH-1:0] ir_q;
   logic [INSTR_WIDTH-1:0] ir_d;
   logic                   ir_ok_q;
   logic                   ir_ok_d;
   logic                   flush_q;
   logic                   flush_d;
   logic                   prd_q;
   logic                   prd_d;

   // data side state
   logic [DADDR_WIDTH-1:0] daddr_q;
   logic [DADDR_WIDTH-1:0] daddr_d;
   logic                   drd_q;
   logic                   drd_d;
   logic                   dwr_q;
   logic                   dwr_d;
   logic [DATA_WIDTH-1:0]  dwdata_q;
   logic [DATA_WIDTH-1:0]  dwdata_d;
   logic [DATA_WIDTH-1:0]  operand_q;
   logic [DATA_WIDTH-1:0]  operand_d;

   // fetch side: program counter, instruction register and squash flag.
   // the word read in phase four goes straight into the ir; a separate
   // prefetch latch would add a cycle and break the jump arithmetic
   always_comb
   begin
      pc_d    = pc_q;
      ir_d    = ir_q;
      ir_ok_d = ir_ok_q;
      flush_d = flush_q;
      // program memory read runs through phases three and four
      prd_d   = ph2 || ph3;
      if (ph3 && ir_ok_q && jump_i)
      begin
         // aim one short: the phase-four increment below lands on the target
         pc_d    = jump_target_i - 1'b1;
         flush_d = 1'b1;
      end
      if (ph4)
      begin
         // captured as phase four ends, in the ir as phase one begins
         ir_d    = prog_data_i;
         // the word fetched behind a jump is loaded but never executed;
         // otherwise each fetch feeds the next execution cycle
         ir_ok_d = !flush_q;
         // a new fetch cycle starts with the increment
         pc_d    = pc_q + 1'b1;
         flush_d = 1'b0;
      end
      if (!nrst_i)
      begin
         // nothing is valid until the first fetch after reset has ended
         pc_d    = PC_RESET[PC_WIDTH-1:0];
         ir_ok_d = 1'b0;
         flush_d = 1'b0;
         prd_d   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      pc_q    <= pc_d;
      ir_q    <= ir_d;
      ir_ok_q <= ir_ok_d;
      flush_q <= flush_d;
      prd_q   <= prd_d;
   end

   // data side: operand read in phase two, result write in phase four.
   // requests are only taken while the ir holds a valid instruction, so
   // a squashed word never touches data memory
   always_comb
   begin
      daddr_d   = daddr_q;
      drd_d     = 1'b0;
      dwr_d     = 1'b0;
      dwdata_d  = dwdata_q;
      operand_d = operand_q;
      if (ph1 && ir_ok_q)
      begin
         // operand address presented for the phase-two read
         daddr_d = mem_addr_i;
         drd_d   = mem_rd_req_i;
      end
      if (ph2 && drd_q)
      begin
         operand_d = dmem_rdata_i;
      end
      if (ph3 && ir_ok_q && mem_wr_req_i)
      begin
         daddr_d  = mem_addr_i;
         dwdata_d = result_i;
         dwr_d    = 1'b1;
      end
      if (!nrst_i)
      begin
         // data registers keep their contents, only the strobes clear
         drd_d = 1'b0;
         dwr_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      daddr_q   <= daddr_d;
      drd_q     <= drd_d;
      dwr_q     <= dwr_d;
      dwdata_q  <= dwdata_d;
      operand_q <= operand_d;
   end

   // pc is the address of the word being fetched this cycle
   assign prog_addr_o   = pc_q;
   assign prog_rd_o     = prd_q;
   assign instr_reg_o   = ir_q;
   assign instr_valid_o = ir_ok_q;
   assign operand_o     = operand_q;
   assign dmem_addr_o   = daddr_q;
   assign dmem_rd_o     = drd_q;
   assign dmem_wr_o     = dwr_q;
   assign dmem_wdata_o  = dwdata_q;

endmodule : qfs_sequencer

// *** testbench/qfs_mem_model.sv ***
`timescale 1ns/100ps
module qfs_mem_model
   import qfs_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic [PC_W-1:0]    prog_addr_i,
   input  wire logic               prog_rd_i,
   output logic      [INSTR_W-1:0] prog_data_o,
   input  wire logic [DADDR_W-1:0] dmem_addr_i,
   input  wire logic               dmem_rd_i,
   input  wire logic               dmem_wr_i,
   input  wire logic [DATA_W-1:0]  dmem_wdata_i,
   output logic      [DATA_W-1:0]  dmem_rdata_o
);
   logic [DATA_W-1:0] ram [128];
   // each word carries its address, so fetch order shows in the ir
   wire [INSTR_W-1:0] word = {3'h5, prog_addr_i};
   // released buses show the inverse, so a late sample never matches
   assign prog_data_o  = prog_rd_i ? word : ~word;
   assign dmem_rdata_o = dmem_rd_i ? ram[dmem_addr_i] : ~ram[dmem_addr_i];
   always_ff @(posedge clk_i)
   begin
      if (dmem_wr_i) ram[dmem_addr_i] <= dmem_wdata_i;
   end
endmodule : qfs_mem_model

// *** testbench/qfs_seq_monitor.sv ***
`timescale 1ns/100ps
module qfs_seq_monitor
   import qfs_pkg::*;
(
   // clock and reset
   input wire logic               sys_clk_i,
   input wire logic               nrst_i,
   // fetch and execute side
   input wire logic [PC_W-1:0]    prog_addr_o,
   input wire logic [INSTR_W-1:0] prog_data_i,
   input wire logic [INSTR_W-1:0] instr_reg_o,
   input wire logic               instr_valid_o,
   input wire logic               jump_i,
   input wire logic [PC_W-1:0]    jump_target_i,
   input wire logic               mem_rd_req_i,
   input wire logic               mem_wr_req_i,
   input wire logic [DADDR_W-1:0] mem_addr_i,
   input wire logic [DATA_W-1:0]  result_i,
   input wire logic [DATA_W-1:0]  operand_o,
   // data memory
   input wire logic [DADDR_W-1:0] dmem_addr_o,
   input wire logic               dmem_rd_o,
   input wire logic               dmem_wr_o,
   input wire logic [DATA_W-1:0]  dmem_wdata_o,
   input wire logic [DATA_W-1:0]  dmem_rdata_i,
   // phases
   input wire logic               phase_one_clock_o,
   input wire logic               phase_two_clock_o,
   input wire logic               phase_three_clock_o,
   input wire logic               phase_four_clock_o
);
   wire p1 = phase_one_clock_o;
   wire p2 = phase_two_clock_o;
   wire p3 = phase_three_clock_o;
   wire p4 = phase_four_clock_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_cycle;
      p2 ##1 p3 ##1 p4 ##1 p1;
   endsequence
   AST_ONEHOT: assert property ($onehot({p1, p2, p3, p4})) else $error("phase overlap");
   AST_ORDER: assert property (p1 |=> s_cycle) else $error("phase order");
   AST_PC: assert property (p1 && $past(p4) |-> prog_addr_o == $past(prog_addr_o) + 1'b1)
      else $error("pc step");
   AST_IR: assert property (p1 && $past(p4) && instr_valid_o |->
      instr_reg_o == $past(prog_data_i)) else $error("ir load");
   AST_HOLD: assert property (!p1 && instr_valid_o |-> $stable(instr_reg_o))
      else $error("ir moved");
   AST_RD: assert property (p1 && instr_valid_o && mem_rd_req_i |=>
      dmem_rd_o && dmem_addr_o == $past(mem_addr_i)) else $error("read");
   AST_OPND: assert property ($fell(dmem_rd_o) |-> p3 && operand_o == $past(dmem_rdata_i))
      else $error("operand");
   AST_WR: assert property (p3 && instr_valid_o && mem_wr_req_i |=>
      dmem_wr_o && dmem_wdata_o == $past(result_i)) else $error("write");
   AST_STROBE: assert property ((dmem_rd_o |-> p2) and (dmem_wr_o |-> p4))
      else $error("strobe phase");
   AST_JUMP: assert property (p3 && instr_valid_o && jump_i |=> ##1 !instr_valid_o
      && prog_addr_o == $past(jump_target_i, 2) ##4 instr_valid_o) else $error("jump");
   AST_RST: assert property (disable iff (1'b0) !nrst_i |=> p1 && !instr_valid_o
      && !dmem_rd_o && !dmem_wr_o) else $error("reset state");
endmodule : qfs_seq_monitor
bind qfs_sequencer qfs_seq_monitor u_mon (.*);

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import qfs_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, jmp = 1'b0, rdq = 1'b0, wrq = 1'b0;
   logic [10:0] tgt = 11'h000, paddr;
   logic [6:0]  maddr = 7'h00, daddr;
   logic [7:0]  res = 8'h00, opnd, wdat, rdat;
   logic [13:0] pdata, ir;
   logic prd, ival, drd, dwr;
   logic [3:0] ph;
   int failures = 0, n_compared = 0;
   always #2.5 sys_clk = ~sys_clk;
   qfs_sequencer u_qfs_sequencer (.sys_clk_i(sys_clk), .nrst_i(nrst), .prog_addr_o(paddr),
      .prog_rd_o(prd), .prog_data_i(pdata), .instr_reg_o(ir), .instr_valid_o(ival),
      .jump_i(jmp), .jump_target_i(tgt), .mem_rd_req_i(rdq), .mem_wr_req_i(wrq),
      .mem_addr_i(maddr), .result_i(res), .operand_o(opnd), .dmem_addr_o(daddr),
      .dmem_rd_o(drd), .dmem_wr_o(dwr), .dmem_wdata_o(wdat), .dmem_rdata_i(rdat),
      .phase_one_clock_o(ph[0]), .phase_two_clock_o(ph[1]), .phase_three_clock_o(ph[2]),
      .phase_four_clock_o(ph[3]));
   qfs_mem_model u_qfs_mem_model (.clk_i(sys_clk), .prog_addr_i(paddr), .prog_rd_i(prd),
      .prog_data_o(pdata), .dmem_addr_i(daddr), .dmem_rd_i(drd), .dmem_wr_i(dwr),
      .dmem_wdata_i(wdat), .dmem_rdata_o(rdat));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // bounded wait for phase k of a valid instruction, seen at a falling edge
   task wph(input int k);
      int n;
      n = 0;
      do begin @(negedge sys_clk); n++; end while (!(ph[k] && ival) && n < 40);
      chk(ph[k] & ival, 1'b1);
   endtask : wph
   task t_seq;
      logic [13:0] b;
      wph(0);
      b = ir;
      for (int i = 1; i < 4; i++)
      begin
         repeat (4) @(negedge sys_clk);
         chk(ir, b + i[13:0]);
         chk(paddr, ir[10:0] + 11'h001);
         chk(ph, 4'h1);
      end
      $display("sequential fetch done");
   endtask : t_seq
   task t_mem;
      wph(2);
      {wrq, maddr, res} = {1'b1, 7'h2A, 8'hC3};
      @(negedge sys_clk) wrq = 1'b0;
      wph(0);
      {rdq, maddr} = {1'b1, 7'h2A};
      @(negedge sys_clk) rdq = 1'b0;
      @(negedge sys_clk);
      chk(opnd, 8'hC3);
      $display("memory read write done");
   endtask : t_mem
   task t_jump;
      wph(2);
      {jmp, tgt} = {1'b1, 11'h155};
      @(negedge sys_clk) jmp = 1'b0;
      @(negedge sys_clk);
      chk(ival, 1'b0);
      repeat (4) @(negedge sys_clk);
      chk({ival, ir}, {1'b1, 3'h5, 11'h155});
      $display("jump done");
   endtask : t_jump
   task t_rst;
      wph(1);
      nrst = 1'b0;
      @(negedge sys_clk);
      chk({ph, ival}, 5'h02);
      repeat (5) @(negedge sys_clk);
      nrst = 1'b1;
      $display("mid-run reset done");
   endtask : t_rst
   initial
   begin
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      t_seq();
      t_mem();
      t_jump();
      t_rst();
      t_seq();
      print_verdict();
   end
   // the tests need some 60 cycles; allow 400, about six and a half times that
   initial
   begin
      #2000;
      failures++;
      print_verdict();
   end
endmodule : testbench
